// file: rtl/dsr_top.sv
// Drive stop, braking switch guard and speed reference release sequencing
//
// Summary of operation
// - Inner loop mode: off, low, high.
// - Stop style: normal or torque ramp-down.
// - Ramp-down enable from terminal, run logic, serial.
// - Run logic source holds run until ramp ends.
// - S-curve abort enable setting passed to generator.
// - Braking switch on only released or 10 s.
// - Timeout forces switch off, raises fault or alarm if it was on.
// - Source 1: speed release follows regulator release.
// - Source 2: speed release waits for brake lifted.
// - Internal source lifts brake once magnetized.
`timescale 1ns/10ps
`include "dsr_defs.svh"

module dsr_top #(
    parameter logic [31:0] DB_CYCLES = 32'(`DSR_DB_CYCLES)
) (
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          rstn_i,
    // Configuration settings
    input  wire dsr_pkg::dsr_cfg_s cfg_i,
    // Pins from the elevator controller
    input  wire logic          run_cmd_i,
    input  wire logic          term_ramp_en_i,
    input  wire logic          brake_lifted_i,
    // Drive logic on the same clock
    input  wire logic          serial_ramp_en_i,
    input  wire logic          reg_release_i,
    input  wire logic          ramp_done_i,
    input  wire logic          magnetized_i,
    input  wire logic          db_demand_i,
    input  wire logic          fault_clear_i,
    // Regulator and reference generator settings
    output logic               ireg_loop_en_o,
    output logic               ireg_loop_high_o,
    output logic               scurve_abort_en_o,
    // Run sequencing
    output logic               internal_run_o,
    output logic               ramp_down_active_o,
    // Braking switch
    output logic               db_switch_o,
    output logic               braking_voltage_fault_o,
    output logic               braking_alarm_o,
    // Release and brake
    output logic               spd_ref_release_o,
    output logic               brake_lift_cmd_o
);

    dsr_pkg::dsr_state_s st;
    dsr_pkg::dsr_state_s next_st;

    logic run_cmd;
    logic term_ramp;
    logic brake_lifted;
    logic ramp_en;
    logic stop_event;
    logic timeout_hit;

    // Synchronised pins, second stage only
    assign run_cmd      = st.run_sync[1];
    assign term_ramp    = st.term_sync[1];
    assign brake_lifted = st.brake_sync[1];

    // Ramp-down enable source select; run logic enables on loss of run
    always_comb begin
        unique case (cfg_i.ramp_src)
            `DSR_RSRC_TERMINAL:  ramp_en = term_ramp;
            `DSR_RSRC_RUN_LOGIC: ramp_en = 1'b1;
            `DSR_RSRC_SERIAL:    ramp_en = serial_ramp_en_i;
            default:             ramp_en = 1'b0;               // Code 0 is illegal
        endcase
    end

    // Stop is the fall of regulator release
    assign stop_event  = st.released_d && !reg_release_i;
    assign timeout_hit = !reg_release_i && !stop_event && (st.db_timer >= DB_CYCLES - 32'h1);

    // Next state of everything
    always_comb begin
        next_st = st;
        next_st.run_sync   = {st.run_sync[0], run_cmd_i};
        next_st.term_sync  = {st.term_sync[0], term_ramp_en_i};
        next_st.brake_sync = {st.brake_sync[0], brake_lifted_i};
        next_st.released_d = reg_release_i;

        // Run sequencing; only the run logic source may stretch the run
        unique case (st.state)
            dsr_pkg::DSR_IDLE: begin
                if (run_cmd) begin
                    next_st.state = dsr_pkg::DSR_RUN;
                end
            end
            dsr_pkg::DSR_RUN: begin
                if (!run_cmd) begin
                    if (cfg_i.stop_style == `DSR_STOP_RAMP &&
                        cfg_i.ramp_src == `DSR_RSRC_RUN_LOGIC) begin
                        next_st.state = dsr_pkg::DSR_RAMP;
                    end else begin
                        next_st.state = dsr_pkg::DSR_IDLE;
                    end
                end
            end
            dsr_pkg::DSR_RAMP: begin
                if (ramp_done_i) begin
                    next_st.state = run_cmd ? dsr_pkg::DSR_RUN : dsr_pkg::DSR_IDLE;
                end
            end
            default: begin
                next_st.state = dsr_pkg::DSR_IDLE;          // Code 2 is illegal
            end
        endcase

        // Braking switch timer: cleared while released, restarts on stop
        if (reg_release_i || stop_event) begin
            next_st.db_timer = 32'h0;
        end else if (st.db_timer < DB_CYCLES - 32'h1) begin
            next_st.db_timer = st.db_timer + 32'h1;
        end
        if (reg_release_i) begin
            next_st.db_timed_out = 1'b0;
        end else if (timeout_hit) begin
            next_st.db_timed_out = 1'b1;
        end

        // Switch allowed while released or inside the window after stop
        next_st.db_switch = db_demand_i && (reg_release_i || !(timeout_hit || st.db_timed_out));

        // Timeout while conducting raises the selected report; set wins over clear
        if (timeout_hit && !st.db_timed_out && st.db_switch) begin
            if (cfg_i.braking_switch_guard_action == `DSR_GUARD_ALARM) begin
                next_st.braking_alarm = 1'b1;
            end else begin
                next_st.braking_voltage_fault = 1'b1;
            end
        end else if (fault_clear_i) begin
            next_st.braking_alarm         = 1'b0;
            next_st.braking_voltage_fault = 1'b0;
        end

        // Brake lift once magnetizing current is up, internal source only
        next_st.brake_lift_cmd = (cfg_i.brake_lift_src == `DSR_LIFT_INTERNAL) &&
                                 (st.state != dsr_pkg::DSR_IDLE) && magnetized_i;
    end

    // Single state register
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Setting decode for the current loop and the S-curve generator
    assign ireg_loop_en_o    = (cfg_i.ireg_loop_sel == `DSR_IREG_LOW) ||
                               (cfg_i.ireg_loop_sel == `DSR_IREG_HIGH);
    assign ireg_loop_high_o  = (cfg_i.ireg_loop_sel == `DSR_IREG_HIGH);
    assign scurve_abort_en_o = (cfg_i.scurve_abort == `DSR_SCURVE_ON);

    // Run outputs; ramp-down only when the ramp stop style is chosen
    assign internal_run_o     = (st.state != dsr_pkg::DSR_IDLE);
    assign ramp_down_active_o = (cfg_i.stop_style == `DSR_STOP_RAMP) && ramp_en &&
                                (st.state == dsr_pkg::DSR_RAMP ||
                                 (st.state == dsr_pkg::DSR_RUN &&
                                  cfg_i.ramp_src != `DSR_RSRC_RUN_LOGIC));

    // Speed release is combinational so it tracks release in the same cycle
    assign spd_ref_release_o = reg_release_i &&
                               (cfg_i.spd_ref_src != `DSR_SREL_BRAKE || brake_lifted);

    assign db_switch_o             = st.db_switch;
    assign braking_voltage_fault_o = st.braking_voltage_fault;
    assign braking_alarm_o         = st.braking_alarm;
    assign brake_lift_cmd_o        = st.brake_lift_cmd;

    // Checks

    sequence s_stop;
        $fell(reg_release_i);
    endsequence

    sequence s_quiet_after_stop;
        !reg_release_i [*2];
    endsequence

    chk_switch_window: assert property (@(posedge clk_i) disable iff (!rstn_i)
        db_switch_o |-> $past(reg_release_i) || !st.db_timed_out)
        else $error("braking switch on outside its window");

    // Timer is zero at the stop edge and one at the next, so it reads one here
    chk_timer_restart: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_stop ##0 s_quiet_after_stop |=> st.db_timer == 32'h1)
        else $error("braking timer did not restart at stop");

    chk_timer_cleared: assert property (@(posedge clk_i) disable iff (!rstn_i)
        reg_release_i |=> st.db_timer == 32'h0)
        else $error("braking timer not held clear while released");

    chk_fault_select: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $rose(braking_alarm_o) |-> $past(cfg_i.braking_switch_guard_action) == `DSR_GUARD_ALARM)
        else $error("alarm raised with fault action selected");

    chk_timeout_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ($rose(braking_voltage_fault_o) || $rose(braking_alarm_o)) |-> !db_switch_o)
        else $error("switch still on after timeout report");

    chk_ramp_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
        st.state == dsr_pkg::DSR_RAMP && !ramp_done_i |=> internal_run_o)
        else $error("run dropped before ramp-down finished");

    chk_ref_brake: assert property (@(posedge clk_i) disable iff (!rstn_i)
        cfg_i.spd_ref_src == `DSR_SREL_BRAKE && !brake_lifted |-> !spd_ref_release_o)
        else $error("speed release before brake lifted");

    chk_ref_follow: assert property (@(posedge clk_i) disable iff (!rstn_i)
        cfg_i.spd_ref_src == `DSR_SREL_REG |-> spd_ref_release_o == reg_release_i)
        else $error("speed release not following regulator release");

    chk_brake_lift: assert property (@(posedge clk_i) disable iff (!rstn_i)
        cfg_i.brake_lift_src == `DSR_LIFT_INTERNAL && internal_run_o && magnetized_i
        |=> brake_lift_cmd_o)
        else $error("brake not lifted once magnetized");

    chk_ireg_decode: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ireg_loop_high_o |-> ireg_loop_en_o)
        else $error("inner loop high without enable");

endmodule

// file: rtl/dsr_defs.svh
// Constants for the drive stop and release sequencing block
`ifndef DSR_DEFS_SVH
`define DSR_DEFS_SVH

// Current regulator inner loop setting
`define DSR_IREG_OFF        2'h0
`define DSR_IREG_LOW        2'h1
`define DSR_IREG_HIGH       2'h2

// Stop style
`define DSR_STOP_NORMAL     1'h0
`define DSR_STOP_RAMP       1'h1

// Ramp-down enable source
`define DSR_RSRC_TERMINAL   2'h1
`define DSR_RSRC_RUN_LOGIC  2'h2
`define DSR_RSRC_SERIAL     2'h3

// S-curve abort
`define DSR_SCURVE_OFF      1'h0
`define DSR_SCURVE_ON       1'h1

// Braking switch guard action
`define DSR_GUARD_FAULT     2'h1
`define DSR_GUARD_ALARM     2'h2

// Speed reference release source
`define DSR_SREL_REG        2'h1
`define DSR_SREL_BRAKE      2'h2

// Brake lift source
`define DSR_LIFT_INTERNAL   2'h1
`define DSR_LIFT_SERIAL     2'h2

// Braking switch window after stop, and control clock rate
`define DSR_DB_TIME_S       10
`define DSR_CLK_HZ          10000000
`define DSR_DB_CYCLES       (`DSR_DB_TIME_S * `DSR_CLK_HZ)

`endif

// file: rtl/dsr_pkg.sv
// Types for the drive stop and release sequencing block
package dsr_pkg;

    // Run sequencing states, Gray coded along idle, run, ramp
    typedef enum logic [1:0] {
        DSR_IDLE = 2'h0,
        DSR_RUN  = 2'h1,
        DSR_RAMP = 2'h3
    } dsr_state_e;

    // Configuration settings applied to the block
    typedef struct packed {
        logic [1:0] ireg_loop_sel;
        logic       stop_style;
        logic [1:0] ramp_src;
        logic       scurve_abort;
        logic [1:0] braking_switch_guard_action;
        logic [1:0] spd_ref_src;
        logic [1:0] brake_lift_src;
    } dsr_cfg_s;

    // Whole register state of the block
    typedef struct packed {
        logic [1:0]  run_sync;
        logic [1:0]  term_sync;
        logic [1:0]  brake_sync;
        dsr_state_e  state;
        logic        released_d;
        logic [31:0] db_timer;
        logic        db_timed_out;
        logic        db_switch;
        logic        braking_voltage_fault;
        logic        braking_alarm;
        logic        brake_lift_cmd;
    } dsr_state_s;

endpackage

// file: testbench/dsr_ctrl_model.sv
// Elevator controller model: run command, ramp enable and brake feedback
`timescale 1ns/10ps
module dsr_ctrl_model (
    // Requests from the bench
    input  wire logic clk_i,
    input  wire logic run_req_i,
    input  wire logic hold_i,
    input  wire logic brake_req_i,
    input  wire logic ramp_done_i,
    // Pins towards the drive
    output logic      run_cmd_o,
    output logic      term_ramp_en_o,
    output logic      brake_lifted_o
);
    logic [1:0] brake_dly;

    initial {run_cmd_o, term_ramp_en_o, brake_lifted_o, brake_dly} = '0;

    // Pins update by non-blocking assignment on the rising edge, so requests that the
    // bench sets at the falling edge are read without a race; the brake is slow to confirm
    always @(posedge clk_i) begin
        run_cmd_o      <= run_req_i | (run_cmd_o & hold_i & ~ramp_done_i);
        term_ramp_en_o <= ~run_req_i & run_cmd_o;
        brake_dly      <= {brake_dly[0], brake_req_i};
        brake_lifted_o <= brake_dly[1];
    end
endmodule

// file: testbench/tb_top.sv
// Self-checking bench for the stop and release sequencing block
`timescale 1ns/10ps
module tb_top;
    logic clk = 1'h0, rstn = 1'h0, run_req = 1'h0, hold = 1'h0, brake_req = 1'h0, ramp_done = 1'h0;
    logic ser_en = 1'h0, reg_rel = 1'h0, magn = 1'h0, db_dem = 1'h0, f_clr = 1'h0;
    logic run_cmd, term_en, brake_lifted, ie, ih, sc, irun, rda, dbs, flt, alm, srel, lift;
    dsr_pkg::dsr_cfg_s cfg = '{2'h0, 1'h0, 2'h1, 1'h0, 2'h1, 2'h1, 2'h1};
    int miscompares = 0, num_checks = 0;

    always #50 clk = ~clk;

    dsr_ctrl_model i_dsr_ctrl_model (.clk_i(clk), .run_req_i(run_req), .hold_i(hold), .brake_req_i(brake_req),
        .ramp_done_i(ramp_done), .run_cmd_o(run_cmd), .term_ramp_en_o(term_en), .brake_lifted_o(brake_lifted));

    // Short braking window keeps the timeout scenario brief
    dsr_top #(.DB_CYCLES(32'h8)) i_dsr_top (.clk_i(clk), .rstn_i(rstn), .cfg_i(cfg), .run_cmd_i(run_cmd),
        .term_ramp_en_i(term_en), .brake_lifted_i(brake_lifted), .serial_ramp_en_i(ser_en),
        .reg_release_i(reg_rel), .ramp_done_i(ramp_done), .magnetized_i(magn), .db_demand_i(db_dem),
        .fault_clear_i(f_clr), .ireg_loop_en_o(ie), .ireg_loop_high_o(ih), .scurve_abort_en_o(sc),
        .internal_run_o(irun), .ramp_down_active_o(rda), .db_switch_o(dbs), .braking_voltage_fault_o(flt),
        .braking_alarm_o(alm), .spd_ref_release_o(srel), .brake_lift_cmd_o(lift));

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic check(input string name, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Every inner loop code and both abort settings
    task automatic t_cfg();
        for (int i = 0; i < 3; i++) begin
            cfg.ireg_loop_sel = 2'(i);
            cyc(1);
            check("ireg_en", i != 0, ie);
            check("ireg_high", i == 2, ih);
        end
        cfg.scurve_abort = 1'h1;
        cyc(1);
        check("scurve_on", 1'h1, sc);
        cfg.scurve_abort = 1'h0;
        cyc(1);
        check("scurve_off", 1'h0, sc);
    endtask

    // Normal stop, then run-logic ramp stop that outlives the run command
    task automatic t_run_logic();
        cfg.ramp_src = 2'h2;
        for (int s = 0; s < 2; s++) begin
            cfg.stop_style = 1'(s);
            run_req = 1'h1;
            cyc(5);
            check("run_up", 1'h1, irun);
            run_req = 1'h0;
            cyc(6);
            check("run_held", s == 1, irun);
            check("ramp_act", s == 1, rda);
            ramp_done = 1'h1;
            cyc(2);
            ramp_done = 1'h0;
            check("run_end", 1'h0, irun);
        end
    endtask

    // Terminal and serial sources: controller keeps the run command
    task automatic t_ext_src();
        hold = 1'h1;
        ser_en = 1'h1;
        for (int s = 1; s < 4; s += 2) begin
            cfg.ramp_src = 2'(s);
            run_req = 1'h1;
            cyc(5);
            run_req = 1'h0;
            cyc(6);
            check("ext_run", 1'h1, irun);
            check("ext_ramp", 1'h1, rda);
            ramp_done = 1'h1;
            cyc(5);
            ramp_done = 1'h0;
            check("ext_end", 1'h0, irun);
        end
        {hold, ser_en, cfg.stop_style} = 3'h0;
    endtask

    // Braking window restarts on each stop, then times out
    task automatic t_guard(input logic [1:0] act);
        cfg.braking_switch_guard_action = act;
        {reg_rel, db_dem} = 2'h3;
        cyc(2);
        check("db_released", 1'h1, dbs);
        reg_rel = 1'h0;
        cyc(5);
        reg_rel = 1'h1;
        cyc(1);
        reg_rel = 1'h0;
        // Window of eight cycles from this stop: still on at eight, off at nine
        cyc(8);
        check("db_restart", 1'h1, dbs);
        cyc(1);
        check("db_forced", 1'h0, dbs);
        check("fault", act == 2'h1, flt);
        check("alarm", act == 2'h2, alm);
        {f_clr, db_dem} = 2'h2;
        cyc(1);
        f_clr = 1'h0;
        cyc(1);
        check("fault_clr", 1'h0, flt | alm);
    endtask

    // Release at once with source 1, only after brake feedback with 2
    task automatic t_release();
        reg_rel = 1'h1;
        cyc(1);
        check("srel_reg", 1'h1, srel);
        cfg.spd_ref_src = 2'h2;
        brake_req = 1'h1;
        cyc(2);
        check("srel_wait", 1'h0, srel);
        cyc(6);
        check("srel_brake", 1'h1, srel);
        {reg_rel, brake_req} = 2'h0;
    endtask

    // Brake lift waits for magnetizing current; serial source never lifts
    task automatic t_lift();
        run_req = 1'h1;
        cyc(6);
        check("lift_nomag", 1'h0, lift);
        magn = 1'h1;
        cyc(2);
        check("lift_mag", 1'h1, lift);
        cfg.brake_lift_src = 2'h2;
        cyc(2);
        check("lift_serial", 1'h0, lift);
        {run_req, magn} = 2'h0;
        cyc(5);
    endtask

    // Hang guard sized well above the whole sequence
    initial begin
        repeat (3000) @(posedge clk);
        miscompares++;
        conclude();
    end

    initial begin
        cyc(2);
        rstn = 1'h1;
        cyc(1);
        check("rst_run", 1'h0, irun);
        check("rst_db", 1'h0, dbs);
        t_cfg();
        t_run_logic();
        t_ext_src();
        t_guard(2'h1);
        t_guard(2'h2);
        t_release();
        t_lift();
        conclude();
    end
endmodule
